/* File: inc/sector_protect_pkg.sv */
// Constants, opcodes and types for the sector protection command block.
// Assumes a 125 MHz system clock sampling an external serial bus.
package sector_protect_pkg;
   // Opcodes
   localparam logic [7:0] OP_VOL_WRITE = 8'hFB;
   localparam logic [7:0] OP_VOL_WRITE_WIDE = 8'hE1;
   localparam logic [7:0] OP_PERS_READ = 8'hFC;
   localparam logic [7:0] OP_PERS_READ_WIDE = 8'hE2;
   localparam logic [7:0] OP_PERS_PROG = 8'hFD;
   localparam logic [7:0] OP_PERS_PROG_WIDE = 8'hE3;
   localparam logic [7:0] OP_PERS_ERASE = 8'hE4;
   localparam logic [7:0] OP_MODE_READ = 8'h2B;
   localparam logic [7:0] OP_MODE_PROG = 8'h2F;
   localparam logic [7:0] OP_LOCK_READ = 8'hA7;
   localparam logic [7:0] OP_LOCK_CLEAR = 8'hA6;
   localparam logic [7:0] OP_FREEZE_SET = 8'h91;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_EXT_READ = 8'h81;
   // Geometry
   localparam int SECTOR_BITS = 6;
   localparam int NUM_SECTORS = 64;
   localparam int SECTOR_LSB = 18;
   localparam int WIDE_SEL_BIT = 7;
   localparam int FREEZE_BIT = 7;
   localparam int LOCK_BIT = 0;
   localparam int WIP_BIT = 0;
   localparam int WEL_BIT = 1;
   // Bit counts of frame phases
   localparam logic [5:0] OPCODE_BITS = 6'h08;
   localparam logic [5:0] ADDR3_BITS = 6'h18;
   localparam logic [5:0] ADDR4_BITS = 6'h20;
   localparam logic [5:0] BYTE_BITS = 6'h08;
   localparam logic [5:0] WORD_BITS = 6'h10;
   // Reset values
   localparam logic [7:0] PROT_CLEAR = 8'hFF;
   localparam logic [7:0] PROT_SET = 8'h00;
   localparam logic [15:0] MODE_RESET = 16'hFFFF;
   localparam logic [7:0] LOCK_RESET = 8'h01;
   localparam logic [7:0] BANK_RESET = 8'h00;
   // Busy times in ns, turned into system clock cycles
   localparam int CLK_NS = 8;
   localparam int PROG_TIME_NS = 800;
   localparam int ERASE_TIME_NS = 4000;
   localparam int PROG_CYCLES = PROG_TIME_NS / CLK_NS;
   localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_NS;
   localparam logic [15:0] BUSY_ONE = 16'h0001;

   typedef enum logic [2:0] {
      ACT_NONE = 3'b000,
      ACT_PERS_PROG = 3'b001,
      ACT_PERS_ERASE = 3'b010,
      ACT_MODE_PROG = 3'b011,
      ACT_LOCK_CLEAR = 3'b100,
      ACT_FREEZE = 3'b101
   } action_e;
endpackage

/* File: inc/busy_if.sv */
// Handshake between the frame decoder and the busy timer.
// Assumes both ends run on the same system clock.
interface busy_if;
   import sector_protect_pkg::*;
   logic start;
   logic isErase;
   logic busy;
   logic done;
   modport ctrl (output start, output isErase, input busy, input done);
   modport timer (input start, input isErase, output busy, output done);
endinterface

/* File: src/busy_timer.sv */
// Busy timer: counts out a program or erase operation.
// Assumes start is a one-cycle pulse from the same clock domain.
module busy_timer
   import sector_protect_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   busy_if.timer bus
);
   typedef struct packed {
      logic [15:0] count;
      logic busy;
      logic done;
   } timer_s;

   timer_s st_r;
   timer_s st_nxt;

   // Load on start, count down, pulse done at the end
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (bus.start && !st_r.busy) begin
         st_nxt.busy = 1'b1;
         st_nxt.count = bus.isErase ? 16'(ERASE_CYCLES) : 16'(PROG_CYCLES);
      end else if (st_r.busy) begin
         if (st_r.count == BUSY_ONE) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end
         st_nxt.count = st_r.count - BUSY_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.busy = st_r.busy;
   assign bus.done = st_r.done;
endmodule

/* File: src/sector_protect_cmds.sv */
// Serial command interpreter for the sector protection commands.
// Assumes a host drives chip enable, serial clock and data lines; the
// serial clock is sampled by clk_sys, well faster than the link clock.
module sector_protect_cmds
   import sector_protect_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ceIn_b,
   input wire logic sclkIn,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   input wire logic fourLineMode,
   input wire logic [7:0] bankAddr,
   input wire logic eraseSuspendReq,
   output logic eraseSuspendRefused,
   output logic writeInProgress,
   output logic writeEnableLatch
);
   typedef struct packed {
      logic [1:0] ceSync;
      logic [1:0] clkSync;
      logic [7:0] io0Sync;
      logic clkPrev;
      logic [7:0] opcode;
      logic [5:0] bitCnt;
      logic [2:0] phase;
      logic [31:0] shiftIn;
      logic [15:0] outWord;
      logic [3:0] outIdx;
      logic [4:0] outLen;
      logic outActive;
      logic write_enable_latch;
      logic [SECTOR_BITS-1:0] sector;
      logic [7:0] dataByte;
      action_e pending;
      logic [NUM_SECTORS-1:0] volBits;
      logic [NUM_SECTORS-1:0] persBits;
      logic [15:0] modeReg;
      logic [7:0] lockReg;
      logic [3:0] ioOut;
      logic [3:0] ioOe;
      logic refused;
   } state_s;

   // Phase codes of a frame
   localparam logic [2:0] PH_OP = 3'd0;
   localparam logic [2:0] PH_ADDR = 3'd1;
   localparam logic [2:0] PH_DATA = 3'd2;
   localparam logic [2:0] PH_OUT = 3'd3;
   localparam logic [2:0] PH_DONE = 3'd4;

   state_s st_r;
   state_s st_nxt;
   busy_if busyBus ();
   logic [3:0] ioSampled;
   logic ceHigh;
   logic clkRise;
   logic clkFall;
   logic [5:0] stepBits;

   // Address width for an opcode
   function automatic logic [5:0] addrBits(input logic [7:0] op,
                                           input logic wide);
      case (op)
         OP_VOL_WRITE, OP_PERS_READ, OP_PERS_PROG:
            addrBits = wide ? ADDR4_BITS : ADDR3_BITS;
         default:
            addrBits = ADDR4_BITS;
      endcase
   endfunction

   // True for opcodes that carry an address
   function automatic logic hasAddr(input logic [7:0] op);
      case (op)
         OP_VOL_WRITE, OP_VOL_WRITE_WIDE, OP_PERS_READ, OP_PERS_READ_WIDE,
         OP_PERS_PROG, OP_PERS_PROG_WIDE: hasAddr = 1'b1;
         default: hasAddr = 1'b0;
      endcase
   endfunction

   busy_timer timer (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .bus(busyBus.timer)
   );

   // Data bits come from the synchroniser's second stage
   assign ioSampled = st_r.io0Sync[7:4];
   assign ceHigh = st_r.ceSync[1];
   assign clkRise = st_r.clkSync[1] && !st_r.clkPrev;
   assign clkFall = !st_r.clkSync[1] && st_r.clkPrev;
   assign stepBits = fourLineMode ? 6'd4 : 6'd1;

   // Frame decode, output shifting and register updates
   always_comb begin
      logic [31:0] shifted;
      logic [7:0] opNow;
      logic [5:0] cntNow;
      logic weOk;
      shifted = '0;
      opNow = '0;
      cntNow = '0;
      weOk = 1'b0;
      st_nxt = st_r;
      st_nxt.ceSync = {st_r.ceSync[0], ceIn_b};
      st_nxt.clkSync = {st_r.clkSync[0], sclkIn};
      st_nxt.io0Sync = {ioIn, st_r.io0Sync[7:4]};
      st_nxt.io0Sync[7:4] = st_r.io0Sync[3:0];
      st_nxt.io0Sync[3:0] = ioIn;
      st_nxt.clkPrev = st_r.clkSync[1];
      st_nxt.refused = eraseSuspendReq && busyBus.busy
         && st_r.pending == ACT_PERS_ERASE;
      busyBus.start = 1'b0;
      busyBus.isErase = 1'b0;
      // A finishing operation consumes the latch before a frame is judged
      weOk = st_r.write_enable_latch && !busyBus.done;

      // Completion first, so a write enable in the same cycle wins
      if (busyBus.done) begin
         case (st_r.pending)
            ACT_PERS_PROG: st_nxt.persBits[st_r.sector] = 1'b0;
            ACT_PERS_ERASE: st_nxt.persBits = '1;
            ACT_LOCK_CLEAR: st_nxt.lockReg[LOCK_BIT] = 1'b0;
            ACT_FREEZE: st_nxt.lockReg[FREEZE_BIT] = 1'b1;
            default: ;
         endcase
         st_nxt.write_enable_latch = 1'b0;
         st_nxt.pending = ACT_NONE;
      end

      if (ceHigh) begin
         // Frame end: act on exact lengths only
         st_nxt.ioOe = '0;
         st_nxt.outActive = 1'b0;
         if (st_r.phase != PH_DONE) begin
            if (st_r.phase == PH_OP && st_r.bitCnt == OPCODE_BITS) begin
               case (st_r.opcode)
                  OP_WRITE_ENABLE: st_nxt.write_enable_latch = !busyBus.busy;
                  OP_PERS_ERASE: if (weOk && !busyBus.busy) begin
                     st_nxt.pending = ACT_PERS_ERASE;
                     busyBus.start = 1'b1;
                     busyBus.isErase = 1'b1;
                  end
                  OP_LOCK_CLEAR: if (weOk && !busyBus.busy) begin
                     st_nxt.pending = ACT_LOCK_CLEAR;
                     busyBus.start = 1'b1;
                  end
                  OP_FREEZE_SET: if (weOk && !busyBus.busy) begin
                     st_nxt.pending = ACT_FREEZE;
                     busyBus.start = 1'b1;
                  end
                  default: ;
               endcase
            end else if (st_r.phase == PH_ADDR
                  && st_r.bitCnt == addrBits(st_r.opcode, bankAddr[WIDE_SEL_BIT])
                  && (st_r.opcode == OP_PERS_PROG
                  || st_r.opcode == OP_PERS_PROG_WIDE)) begin
               if (weOk && !busyBus.busy) begin
                  st_nxt.pending = ACT_PERS_PROG;
                  busyBus.start = 1'b1;
               end
            end else if (st_r.phase == PH_DATA) begin
               if ((st_r.opcode == OP_VOL_WRITE
                     || st_r.opcode == OP_VOL_WRITE_WIDE)
                     && st_r.bitCnt == BYTE_BITS && !busyBus.busy) begin
                  st_nxt.volBits[st_r.sector] =
                     (st_r.shiftIn[7:0] == PROT_SET) ? 1'b0 : 1'b1;
               end else if (st_r.opcode == OP_MODE_PROG
                     && st_r.bitCnt == WORD_BITS
                     && weOk && !busyBus.busy) begin
                  st_nxt.pending = ACT_MODE_PROG;
                  st_nxt.dataByte = st_r.shiftIn[7:0];
                  st_nxt.modeReg = {st_r.shiftIn[7:0], st_r.shiftIn[15:8]};
                  busyBus.start = 1'b1;
               end
            end
         end
         st_nxt.phase = PH_OP;
         st_nxt.bitCnt = '0;
         st_nxt.opcode = '0;
      end else if (clkRise && st_r.phase != PH_OUT
            && st_r.phase != PH_DONE) begin
         // Shift in one or four bits per rising edge
         shifted = fourLineMode ? {st_r.shiftIn[27:0], ioSampled}
            : {st_r.shiftIn[30:0], ioSampled[0]};
         cntNow = st_r.bitCnt + stepBits;
         st_nxt.shiftIn = shifted;
         st_nxt.bitCnt = cntNow;
         if (st_r.phase == PH_OP && cntNow == OPCODE_BITS) begin
            opNow = shifted[7:0];
            st_nxt.opcode = opNow;
            st_nxt.bitCnt = '0;
            st_nxt.shiftIn = '0;
            if (hasAddr(opNow)) begin
               st_nxt.phase = PH_ADDR;
            end else begin
               case (opNow)
                  OP_MODE_READ: begin
                     st_nxt.phase = PH_OUT;
                     st_nxt.outWord = st_r.modeReg;
                     st_nxt.outLen = 5'd16;
                  end
                  OP_LOCK_READ: begin
                     st_nxt.phase = PH_OUT;
                     st_nxt.outWord = {st_r.lockReg, st_r.lockReg};
                     st_nxt.outLen = 5'd8;
                  end
                  OP_STATUS_READ, OP_EXT_READ: begin
                     st_nxt.phase = PH_OUT;
                     st_nxt.outWord = {6'h00, st_r.write_enable_latch, busyBus.busy,
                        6'h00, st_r.write_enable_latch, busyBus.busy};
                     st_nxt.outLen = 5'd8;
                  end
                  OP_MODE_PROG: st_nxt.phase = PH_DATA;
                  default: st_nxt.bitCnt = OPCODE_BITS; // hold for end check
               endcase
               st_nxt.outIdx = '0;
            end
         end else if (st_r.phase == PH_OP && st_r.bitCnt == OPCODE_BITS) begin
            st_nxt.phase = PH_DONE; // Too long: dropped
         end else if (st_r.phase == PH_ADDR && cntNow ==
               addrBits(st_r.opcode, bankAddr[WIDE_SEL_BIT])) begin
            st_nxt.sector = shifted[SECTOR_LSB +: SECTOR_BITS];
            st_nxt.bitCnt = cntNow;
            if (st_r.opcode == OP_PERS_READ
                  || st_r.opcode == OP_PERS_READ_WIDE) begin
               st_nxt.outIdx = '0;
               st_nxt.outLen = 5'd8;
               st_nxt.outWord = {8'h00,
                  st_r.persBits[shifted[SECTOR_LSB +: SECTOR_BITS]]
                  ? PROT_CLEAR : PROT_SET};
               st_nxt.phase = fourLineMode ? PH_DONE : PH_OUT;
            end else if (st_r.opcode == OP_VOL_WRITE
                  || st_r.opcode == OP_VOL_WRITE_WIDE) begin
               st_nxt.phase = PH_DATA;
               st_nxt.bitCnt = '0;
               st_nxt.shiftIn = '0;
            end
         end else if (st_r.phase == PH_ADDR && st_r.bitCnt
               == addrBits(st_r.opcode, bankAddr[WIDE_SEL_BIT])) begin
            st_nxt.phase = PH_DONE; // Program frame overran its address
         end else if (st_r.phase == PH_DATA && st_r.bitCnt == WORD_BITS) begin
            st_nxt.phase = PH_DONE;
         end else if (st_r.phase == PH_DATA && st_r.bitCnt == BYTE_BITS
               && st_r.opcode != OP_MODE_PROG) begin
            st_nxt.phase = PH_DONE;
         end
      end else if (clkFall && st_r.phase == PH_OUT) begin
         // Low byte first, MSB first; word wraps so the value repeats
         st_nxt.outActive = 1'b1;
         if (fourLineMode) begin
            st_nxt.ioOe = 4'hF;
            st_nxt.ioOut = st_r.outWord[{st_r.outIdx[3], ~st_r.outIdx[2],
               2'b11} -: 4];
            st_nxt.outIdx = (5'(st_r.outIdx) + 5'd4 >= st_r.outLen)
               ? 4'h0 : st_r.outIdx + 4'h4;
         end else begin
            st_nxt.ioOe = 4'h2;
            st_nxt.ioOut = {2'b00,
               st_r.outWord[{st_r.outIdx[3], ~st_r.outIdx[2:0]}], 1'b0};
            st_nxt.outIdx = (5'(st_r.outIdx) + 5'd1 >= st_r.outLen)
               ? 4'h0 : st_r.outIdx + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{ceSync: 2'b11, clkSync: 2'b00, io0Sync: 8'h00,
            clkPrev: 1'b0, opcode: 8'h00, bitCnt: 6'h00, phase: PH_DONE,
            shiftIn: 32'h0, outWord: 16'h0, outIdx: 4'h0, outLen: 5'h0,
            outActive: 1'b0, write_enable_latch: 1'b0, sector: '0, dataByte: 8'h00,
            pending: ACT_NONE, volBits: '1, persBits: '1,
            modeReg: MODE_RESET, lockReg: LOCK_RESET, ioOut: 4'h0,
            ioOe: 4'h0, refused: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops; busy flag held by the timer
   assign ioOut = st_r.ioOut;
   assign ioOe = st_r.ioOe;
   assign eraseSuspendRefused = st_r.refused;
   assign writeInProgress = busyBus.busy;
   assign writeEnableLatch = st_r.write_enable_latch;
endmodule

/* File: test/sector_protect_cmds_asserts.sv */
// Checker for the sector protection command block, bound to its top.
// Assumes one clock domain, clk_sys, and an active low reset.
module sector_protect_cmds_asserts
   import sector_protect_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ceIn_b,
   input wire logic sclkIn,
   input wire logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe,
   input wire logic fourLineMode,
   input wire logic [7:0] bankAddr,
   input wire logic eraseSuspendReq,
   input wire logic eraseSuspendRefused,
   input wire logic writeInProgress,
   input wire logic writeEnableLatch
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG_LO = PROG_CYCLES - 2;
   localparam int PROG_HI = PROG_CYCLES + 2;
   localparam int ERASE_LO = ERASE_CYCLES - 2;
   localparam int ERASE_HI = ERASE_CYCLES + 2;
   localparam int ERASE_MID = PROG_HI + 4;
   localparam int ERASE_EDGE = ERASE_CYCLES - 4;
   logic [9:0] busyCnt_r;
   logic [3:0] sinceFall_r;
   logic sclkPrev_r;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // Busy length and cycles since the last serial clock fall
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         busyCnt_r <= 10'h000;
         sinceFall_r <= 4'hF;
         sclkPrev_r <= 1'b0;
      end else begin
         busyCnt_r <= writeInProgress ? busyCnt_r + 10'h001 : 10'h000;
         sclkPrev_r <= sclkIn;
         if (sclkPrev_r && !sclkIn)
            sinceFall_r <= 4'h0;
         else if (sinceFall_r != 4'hF)
            sinceFall_r <= sinceFall_r + 4'h1;
      end
   end

   a_oe_release: assert property (ceIn_b [*6] |-> ioOe == 4'h0)
      else $error("output enable held while deselected");
   a_latch_cleared: assert property (
      $fell(writeInProgress) |-> ##[0:3] !writeEnableLatch)
      else $error("latch not cleared after operation");
   a_start_needs_latch: assert property (
      $rose(writeInProgress) |-> writeEnableLatch)
      else $error("operation started without latch");
   a_start_on_ce: assert property (
      $rose(writeInProgress) |-> ceIn_b && !sclkIn)
      else $error("operation started inside a frame");
   a_busy_length: assert property ($fell(writeInProgress) |->
      busyCnt_r inside {[PROG_LO:PROG_HI], [ERASE_LO:ERASE_HI]})
      else $error("busy time out of range");
   a_refuse_cause: assert property ($rose(eraseSuspendRefused) |->
      $past(eraseSuspendReq) && $past(writeInProgress))
      else $error("suspend refused without request");
   a_refuse_given: assert property (eraseSuspendReq &&
      busyCnt_r inside {[ERASE_MID:ERASE_EDGE]} |=> eraseSuspendRefused)
      else $error("suspend during erase not refused");
   a_latch_held: assert property (
      writeInProgress && $past(writeInProgress) |-> writeEnableLatch)
      else $error("latch dropped during operation");
   a_out_on_fall: assert property (ioOe[1] && $past(ioOe[1]) &&
      $changed(ioOut[1]) |-> sinceFall_r <= 4'h6)
      else $error("output changed away from clock fall");
endmodule

bind sector_protect_cmds sector_protect_cmds_asserts chk (.clk_sys, .rst_b,
   .ceIn_b, .sclkIn, .ioIn, .ioOut, .ioOe, .fourLineMode, .bankAddr,
   .eraseSuspendReq, .eraseSuspendRefused, .writeInProgress,
   .writeEnableLatch);

/* File: test/serial_host_model.sv */
// Host controller model driving chip enable, serial clock and data.
// Assumes mode 0 framing with a 64 ns serial clock, idle low, timed
// off the system clock so every change lands on its rising edge.
module serial_host_model (
   input wire logic clk_sys,
   output logic ceIn_b,
   output logic sclkIn,
   output logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic oeSeen;

   // Deselected, clock parked low
   initial begin
      ceIn_b = 1'b1;
      sclkIn = 1'b0;
      ioIn = 4'hA;
      oeSeen = 1'b0;
   end

   // Half a serial clock period: four system clocks
   task automatic half();
      repeat (4) @(posedge clk_sys);
   endtask

   // One frame: nb bits out MSB first, then nr clocks of read
   task automatic frame(input logic [63:0] tx, input int nb, input int nr,
                        input logic quad, output logic [31:0] rd);
      int i;
      int w;
      w = quad ? 4 : 1;
      rd = 32'h0;
      oeSeen = 1'b0;
      @(posedge clk_sys) ceIn_b <= 1'b0;
      half();
      for (i = nb; i > 0; i -= w) begin
         if (quad) begin
            ioIn <= tx[i-1 -: 4];
         end else begin
            ioIn[0] <= tx[i-1];
         end
         half();
         sclkIn <= 1'b1;
         half();
         sclkIn <= 1'b0;
      end
      ioIn <= ~ioIn; // Released line, not the last value
      for (i = 0; i < nr; i++) begin
         half();
         sclkIn <= 1'b1;
         rd = quad ? {rd[27:0], ioOut} : {rd[30:0], ioOut[1]};
         oeSeen |= (ioOe != 4'h0);
         half();
         sclkIn <= 1'b0;
      end
      half();
      ceIn_b <= 1'b1;
      ioIn <= ~ioIn;
      half();
      half();
   endtask
endmodule

/* File: test/sector_protect_cmds_bench.sv */
// Self-checking bench for the sector protection command block.
// Assumes the host model frames all serial traffic.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   err_total++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module sector_protect_cmds_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sector_protect_pkg::*;
   logic clk_sys, rst_b, ceIn_b, sclkIn, fourLineMode, eraseSuspendReq;
   logic eraseSuspendRefused, writeInProgress, writeEnableLatch;
   logic [3:0] ioIn, ioOut, ioOe;
   logic [7:0] bankAddr;
   logic [31:0] rd;
   int err_total = 0;
   int n_compared = 0;

   sector_protect_cmds dut (.clk_sys, .rst_b, .ceIn_b, .sclkIn, .ioIn,
      .ioOut, .ioOe, .fourLineMode, .bankAddr, .eraseSuspendReq,
      .eraseSuspendRefused, .writeInProgress, .writeEnableLatch);
   serial_host_model host (.clk_sys, .ceIn_b, .sclkIn, .ioIn, .ioOut,
      .ioOe);

   // System clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic fr(input logic [63:0] tx, input int nb, input int nr);
      host.frame(tx, nb, nr, fourLineMode, rd);
   endtask

   task automatic write_en();
      fr(64'h06, 8, 0);
   endtask

   // Poll status until the busy bit clears
   task automatic idle();
      int k;
      for (k = 0; k < 40; k++) begin
         fr(64'h05, 8, 8);
         if (rd[0] === 1'b0)
            return;
      end
      err_total++;
      finish_test();
   endtask

   task automatic t_pers();
      fr({8'hFB, 24'h140000, 8'h00}, 40, 0);
      `CHK("vol_latch", 1'b0, writeEnableLatch)
      fr({8'hFC, 24'h140000}, 32, 16);
      `CHK("pers_init", 16'hFFFF, rd[15:0])
      `CHK("read_oe", 1'b1, host.oeSeen)
      fr({8'hFD, 24'h140000}, 32, 0);
      `CHK("prog_refused", 1'b0, writeInProgress)
      write_en();
      fr({8'hE3, 32'h00140000}, 40, 0);
      `CHK("prog_busy", 1'b1, writeInProgress)
      idle();
      `CHK("prog_latch", 1'b0, writeEnableLatch)
      @(posedge clk_sys) bankAddr <= 8'h80;
      @(posedge clk_sys);
      fr({8'hFC, 32'h00140000}, 40, 16);
      `CHK("pers_wide", 16'h0000, rd[15:0])
      @(posedge clk_sys) bankAddr <= 8'h00;
      fr({8'hE2, 32'h00180000}, 40, 8);
      `CHK("pers_other", 8'hFF, rd[7:0])
      $display("test persistent done");
   endtask

   task automatic t_erase();
      write_en();
      fr(64'h1C8, 9, 0);
      `CHK("erase_len", 1'b0, writeInProgress)
      fr(64'hE4, 8, 0);
      `CHK("erase_busy", 1'b1, writeInProgress)
      @(posedge clk_sys) eraseSuspendReq <= 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK("suspend", 1'b1, eraseSuspendRefused)
      fr(64'h05, 8, 8);
      `CHK("poll_busy", 2'b11, rd[1:0])
      `CHK("suspend_late", 1'b1, eraseSuspendRefused)
      @(posedge clk_sys) eraseSuspendReq <= 1'b0;
      idle();
      `CHK("erase_latch", 1'b0, writeEnableLatch)
      fr({8'hFC, 24'h140000}, 32, 8);
      `CHK("erase_all", 8'hFF, rd[7:0])
      $display("test erase done");
   endtask

   task automatic t_mode();
      fr(64'h2B, 8, 32);
      `CHK("mode_init", 32'hFFFFFFFF, rd)
      write_en();
      fr({8'h2F, 8'h34}, 16, 0);
      `CHK("mode_short", 1'b0, writeInProgress)
      fr({8'h2F, 16'h3412}, 24, 0);
      `CHK("mode_busy", 1'b1, writeInProgress)
      idle();
      `CHK("mode_latch", 1'b0, writeEnableLatch)
      fr(64'h2B, 8, 32);
      `CHK("mode_val", 32'h34123412, rd)
      $display("test mode done");
   endtask

   task automatic t_lock();
      fr(64'hA7, 8, 16);
      `CHK("lock_init", 16'h0101, rd[15:0])
      write_en();
      fr(64'hA6, 8, 0);
      `CHK("clr_busy", 1'b1, writeInProgress)
      idle();
      fr(64'hA7, 8, 8);
      `CHK("lock_clr", 8'h00, rd[7:0])
      fr(64'h91, 8, 0);
      idle();
      fr(64'hA7, 8, 8);
      `CHK("frz_refused", 8'h00, rd[7:0])
      write_en();
      fr(64'h91, 8, 0);
      `CHK("frz_busy", 1'b1, writeInProgress)
      idle();
      fr(64'hA7, 8, 16);
      `CHK("lock_frz", 16'h8080, rd[15:0])
      $display("test lock done");
   endtask

   task automatic t_quad();
      @(posedge clk_sys) fourLineMode <= 1'b1;
      @(posedge clk_sys);
      fr({8'hFC, 24'h140000}, 32, 4);
      `CHK("quad_oe", 1'b0, host.oeSeen)
      fr(64'h2B, 8, 4);
      `CHK("quad_mode", 16'h3412, rd[15:0])
      `CHK("quad_mode_oe", 1'b1, host.oeSeen)
      @(posedge clk_sys) fourLineMode <= 1'b0;
      $display("test quad done");
   endtask

   // Reset, then the scenarios in turn
   initial begin
      rst_b = 1'b0;
      fourLineMode = 1'b0;
      bankAddr = 8'h00;
      eraseSuspendReq = 1'b0;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk_sys);
      t_pers();
      t_erase();
      t_mode();
      t_lock();
      t_quad();
      finish_test();
   end
endmodule
